// [rtl/eia_map.svh]
`ifndef EIA_MAP_SVH
`define EIA_MAP_SVH

// register offsets
`define EIA_OFF_STATUS 8'h08
`define EIA_OFF_LIVECRC 8'h09
`define EIA_OFF_STORCRC 8'h0a
`define EIA_OFF_RDLOC 8'h0b
`define EIA_OFF_RDWORD 8'h0c
`define EIA_OFF_PRLOC 8'h0d
`define EIA_OFF_PRDATA 8'h0e

// status word bit positions
`define EIA_ST_FETCH 0
`define EIA_ST_BUSY 4
`define EIA_ST_CRCERR 5
`define EIA_ST_WRERR 8

// reset values and constants
`define EIA_RST16 16'h0000
`define EIA_RST6 6'h00
`define EIA_LOC_STEP 6'h01
`define EIA_CRC_POLY 16'h1021
`define EIA_LOC_MSB 5
`define EIA_WORD_MSB 15

`endif

// [rtl/eia_pkg.sv]
package eia_pkg;
	typedef enum logic [1:0] {
		EIA_IDLE = 2'h0,
		EIA_FETCH = 2'h1,
		EIA_PROG = 2'h2
	} eia_state_t;
endpackage

// [rtl/eia_port.sv]
`timescale 1ns/1ps
`include "eia_map.svh"
// Notes on behaviour
// - status word at 0x8, reads zero after reset
// - running crc of fetched words at 0x9
// - stored crc at 0xA, compare sets status
// - write 0xB starts readback at location
// - write 0xB fetches the written location immediately
// - read 0xC returns word one past location
// - each 0xC read while idle advances and fetches next
// - write 0xD sets programming start location
// - data write programs word at given location
// - each 0xE write while idle advances and programs next
// - busy bit 4 during program; 0xB/0xC/0xD/0xE ops refused, other reads allowed
// - read-clear error if op during write phase
// - crc error bit on configuration mismatch
module eia_port (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RSTN,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	// eeprom array
	output logic [5:0] EE_ADDR,
	output logic EE_RD,
	output logic EE_WR,
	output logic [15:0] EE_WDATA,
	input wire logic [15:0] EE_RDATA,
	input wire logic EE_RVALID,
	input wire logic EE_DONE,
	// configuration crc check
	input wire logic CFG_START,
	input wire logic CFG_END,
	input wire logic [15:0] CFG_STORED_CRC
);

	eia_pkg::eia_state_t state_reg, state_next;
	logic [5:0] rd_ptr_reg, rd_ptr_next;
	logic [5:0] wr_ptr_reg, wr_ptr_next;
	logic chain_reg, chain_next;
	logic [15:0] word_reg, word_next;
	logic [15:0] rdloc_reg, prloc_reg;
	logic [15:0] live_reg, stored_reg;
	logic crcerr_reg, wrerr_reg;
	logic [5:0] ee_addr_next;
	logic ee_rd_next, ee_wr_next;

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [15:0] d);
		logic [15:0] c;
		c = crc;
		for (int i = `EIA_WORD_MSB; i >= 0; i--) begin
			c = (c[15] ^ d[i]) ? ((c << 1) ^ `EIA_CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

	// decode
	wire wr_b = REG_WR && (REG_ADDR == `EIA_OFF_RDLOC);
	wire rd_c = REG_RD && (REG_ADDR == `EIA_OFF_RDWORD);
	wire wr_d = REG_WR && (REG_ADDR == `EIA_OFF_PRLOC);
	wire wr_e = REG_WR && (REG_ADDR == `EIA_OFF_PRDATA);
	wire rd_st = REG_RD && (REG_ADDR == `EIA_OFF_STATUS);
	wire idle = (state_reg == eia_pkg::EIA_IDLE);
	wire phase_busy = (state_reg == eia_pkg::EIA_PROG);
	wire op_req = wr_b | rd_c | wr_d | wr_e;
	wire op_refused = op_req && phase_busy;
	wire go_b = wr_b && idle;
	wire go_c = rd_c && idle;
	wire go_d = wr_d && idle;
	wire go_e = wr_e && idle;
	wire [15:0] live_step = EE_RVALID ? crc_step(live_reg, EE_RDATA) : live_reg;

	// status word, unlisted bits read zero
	wire fetch_pending = (state_reg == eia_pkg::EIA_FETCH);
	wire [15:0] status_word = (16'(fetch_pending) << `EIA_ST_FETCH) |
		(16'(phase_busy) << `EIA_ST_BUSY) |
		(16'(crcerr_reg) << `EIA_ST_CRCERR) |
		(16'(wrerr_reg) << `EIA_ST_WRERR);

	// read mux
	wire [15:0] rdata_next =
		(REG_ADDR == `EIA_OFF_STATUS) ? status_word :
		(REG_ADDR == `EIA_OFF_LIVECRC) ? live_reg :
		(REG_ADDR == `EIA_OFF_STORCRC) ? stored_reg :
		(REG_ADDR == `EIA_OFF_RDLOC) ? rdloc_reg :
		(REG_ADDR == `EIA_OFF_RDWORD) ? word_reg :
		(REG_ADDR == `EIA_OFF_PRLOC) ? prloc_reg : `EIA_RST16;

	// next values of the host-visible registers
	wire [15:0] rdloc_next = go_b ? REG_WDATA : rdloc_reg;
	wire [15:0] prloc_next = go_d ? REG_WDATA : prloc_reg;
	wire [15:0] reg_rdata_next = REG_RD ? rdata_next : REG_RDATA;
	wire [15:0] ee_wdata_next = go_e ? REG_WDATA : EE_WDATA;
	// a new configuration pass restarts the live crc
	wire [15:0] live_next = CFG_START ? `EIA_RST16 : live_step;
	wire [15:0] stored_next = CFG_END ? CFG_STORED_CRC : stored_reg;
	wire crc_mismatch = (live_reg != CFG_STORED_CRC);
	wire crcerr_next = CFG_END ? crc_mismatch : crcerr_reg;
	// a refusal in the clearing read cycle still sets the flag
	wire wrerr_next = op_refused | (wrerr_reg & ~rd_st);

	// sequencer
	always_comb begin
		state_next = state_reg;
		rd_ptr_next = rd_ptr_reg;
		wr_ptr_next = wr_ptr_reg;
		chain_next = chain_reg;
		word_next = word_reg;
		ee_addr_next = EE_ADDR;
		ee_rd_next = 1'b0;
		ee_wr_next = 1'b0;
		unique case (state_reg)
			eia_pkg::EIA_IDLE: begin
				if (go_b) begin
					ee_addr_next = REG_WDATA[`EIA_LOC_MSB:0];
					ee_rd_next = 1'b1;
					rd_ptr_next = REG_WDATA[`EIA_LOC_MSB:0] + `EIA_LOC_STEP;
					chain_next = 1'b1;
					state_next = eia_pkg::EIA_FETCH;
				end else if (go_c) begin
					ee_addr_next = rd_ptr_reg;
					ee_rd_next = 1'b1;
					rd_ptr_next = rd_ptr_reg + `EIA_LOC_STEP;
					chain_next = 1'b0;
					state_next = eia_pkg::EIA_FETCH;
				end else if (go_d) begin
					wr_ptr_next = REG_WDATA[`EIA_LOC_MSB:0];
				end else if (go_e) begin
					ee_addr_next = wr_ptr_reg;
					ee_wr_next = 1'b1;
					wr_ptr_next = wr_ptr_reg + `EIA_LOC_STEP;
					state_next = eia_pkg::EIA_PROG;
				end
			end
			eia_pkg::EIA_FETCH: begin
				if (EE_RVALID) begin
					word_next = EE_RDATA;
					if (chain_reg) begin
						ee_addr_next = rd_ptr_reg;
						ee_rd_next = 1'b1;
						rd_ptr_next = rd_ptr_reg + `EIA_LOC_STEP;
						chain_next = 1'b0;
					end else begin
						state_next = eia_pkg::EIA_IDLE;
					end
				end
			end
			eia_pkg::EIA_PROG: begin
				if (EE_DONE) begin
					state_next = eia_pkg::EIA_IDLE;
				end
			end
			default: begin
				state_next = eia_pkg::EIA_IDLE;
			end
		endcase
	end

	// sequencer state and location counters
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_reg <= eia_pkg::EIA_IDLE;
			rd_ptr_reg <= `EIA_RST6;
			wr_ptr_reg <= `EIA_RST6;
			chain_reg <= 1'b0;
			word_reg <= `EIA_RST16;
		end else begin
			state_reg <= state_next;
			rd_ptr_reg <= rd_ptr_next;
			wr_ptr_reg <= wr_ptr_next;
			chain_reg <= chain_next;
			word_reg <= word_next;
		end
	end

	// array requests, strobes last one cycle
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			EE_ADDR <= `EIA_RST6;
			EE_RD <= 1'b0;
			EE_WR <= 1'b0;
			EE_WDATA <= `EIA_RST16;
		end else begin
			EE_ADDR <= ee_addr_next;
			EE_RD <= ee_rd_next;
			EE_WR <= ee_wr_next;
			EE_WDATA <= ee_wdata_next;
		end
	end

	// register file
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rdloc_reg <= `EIA_RST16;
			prloc_reg <= `EIA_RST16;
			REG_RDATA <= `EIA_RST16;
		end else begin
			rdloc_reg <= rdloc_next;
			prloc_reg <= prloc_next;
			REG_RDATA <= reg_rdata_next;
		end
	end

	// live and stored crc
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			live_reg <= `EIA_RST16;
			stored_reg <= `EIA_RST16;
		end else begin
			live_reg <= live_next;
			stored_reg <= stored_next;
		end
	end

	// sticky status flags
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			crcerr_reg <= 1'b0;
			wrerr_reg <= 1'b0;
		end else begin
			crcerr_reg <= crcerr_next;
			wrerr_reg <= wrerr_next;
		end
	end

endmodule

// [test/eia_monitor.sv]
`timescale 1ns/1ps
module eia_monitor (
	// design ports
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_WDATA,
	input wire logic [15:0] REG_RDATA,
	input wire logic [5:0] EE_ADDR,
	input wire logic EE_RD,
	input wire logic EE_WR,
	input wire logic [15:0] EE_WDATA,
	input wire logic EE_RVALID
);
	wire [5:0] wloc = REG_WDATA[5:0];
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	a_fetch_pulse: assert property (EE_RD |=> !EE_RD) else $error("rd pulse");
	a_prog_pulse: assert property (EE_WR |=> !EE_WR) else $error("wr pulse");
	a_single_op: assert property (!(EE_WR && EE_RD)) else $error("overlap");
	a_prog_data: assert property (EE_WR |-> $past(REG_ADDR) == 8'h0e
		&& $past(REG_WR) && EE_WDATA == $past(REG_WDATA)) else $error("wr data");
	a_first_fetch: assert property ($past(REG_WR) && $past(REG_ADDR) == 8'h0b && EE_RD
		|-> EE_ADDR == $past(wloc)) else $error("rd loc");
	a_next_loc: assert property (EE_RD && $past(EE_RVALID)
		|-> EE_ADDR == $past(EE_ADDR) + 6'h01) else $error("next loc");
	a_unmapped_zero: assert property (REG_RD && REG_ADDR == 8'h00
		|=> REG_RDATA == 16'h0000) else $error("unmapped");
	a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA)) else $error("rdata");
endmodule
bind eia_port eia_monitor eia_monitor_inst (
	.SYS_CLK(SYS_CLK),
	.RSTN(RSTN),
	.REG_ADDR(REG_ADDR),
	.REG_WR(REG_WR),
	.REG_RD(REG_RD),
	.REG_WDATA(REG_WDATA),
	.REG_RDATA(REG_RDATA),
	.EE_ADDR(EE_ADDR),
	.EE_RD(EE_RD),
	.EE_WR(EE_WR),
	.EE_WDATA(EE_WDATA),
	.EE_RVALID(EE_RVALID)
);

// [test/eia_mem.sv]
`timescale 1ns/1ps
module eia_mem (
	// array side
	input wire logic SYS_CLK,
	input wire logic [5:0] EE_ADDR,
	input wire logic EE_RD,
	input wire logic EE_WR,
	input wire logic [15:0] EE_WDATA,
	output logic [15:0] EE_RDATA = 16'h0000,
	output logic EE_RVALID = 1'b0,
	output logic EE_DONE = 1'b0
);
	logic [15:0] mem [64];
	logic [5:0] ra = 6'h00;
	int rc = 0;
	int wc = 0;
	initial for (int i = 0; i < 64; i++) mem[i] = 16'h5a00 + 16'(i);
	// odd locations answer fast, even slow; idle data toggles
	always @(posedge SYS_CLK) begin
		EE_RVALID <= rc == 1;
		EE_RDATA <= (rc == 1) ? mem[ra] : ~EE_RDATA;
		EE_DONE <= wc == 1;
		rc <= EE_RD ? (EE_ADDR[0] ? 1 : 4) : rc - int'(rc > 0);
		wc <= EE_WR ? 8 : wc - int'(wc > 0);
		if (EE_RD) ra <= EE_ADDR;
		if (EE_WR) mem[EE_ADDR] <= EE_WDATA;
	end
endmodule

// [test/eia_port_test.sv]
`timescale 1ns/1ps
module eia_port_test;
	logic SYS_CLK = 0;
	logic RSTN = 0;
	logic [7:0] REG_ADDR = 8'h00;
	logic REG_WR = 0;
	logic REG_RD = 0;
	logic CFG_START = 0;
	logic CFG_END = 0;
	logic [15:0] REG_WDATA = 16'h0000;
	logic [15:0] CFG_STORED_CRC = 16'h0000;
	logic [15:0] REG_RDATA, EE_WDATA, EE_RDATA, crc, v;
	logic [5:0] EE_ADDR;
	logic EE_RD, EE_WR, EE_RVALID, EE_DONE;
	int err_count = 0;
	int comparisons = 0;
	eia_port eia_port_inst (
		.SYS_CLK(SYS_CLK),
		.RSTN(RSTN),
		.REG_ADDR(REG_ADDR),
		.REG_WR(REG_WR),
		.REG_RD(REG_RD),
		.REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA),
		.EE_ADDR(EE_ADDR),
		.EE_RD(EE_RD),
		.EE_WR(EE_WR),
		.EE_WDATA(EE_WDATA),
		.EE_RDATA(EE_RDATA),
		.EE_RVALID(EE_RVALID),
		.EE_DONE(EE_DONE),
		.CFG_START(CFG_START),
		.CFG_END(CFG_END),
		.CFG_STORED_CRC(CFG_STORED_CRC)
	);
	eia_mem eia_mem_inst (
		.SYS_CLK(SYS_CLK),
		.EE_ADDR(EE_ADDR),
		.EE_RD(EE_RD),
		.EE_WR(EE_WR),
		.EE_WDATA(EE_WDATA),
		.EE_RDATA(EE_RDATA),
		.EE_RVALID(EE_RVALID),
		.EE_DONE(EE_DONE)
	);
	initial forever #50 SYS_CLK = ~SYS_CLK;
	task final_report;
		$display("mismatches %0d of %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task op(input logic [7:0] a, input logic w, input logic [15:0] d);
		@(negedge SYS_CLK);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = w;
		REG_RD = !w;
		@(negedge SYS_CLK);
		REG_WR = 0;
		REG_RD = 0;
		v = REG_RDATA;
	endtask
	task check(input logic [7:0] a, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR reg %h expected %h seen %h", a, exp, seen);
		end
	endtask
	task rc(input logic [7:0] a, input logic [15:0] e);
		op(a, 0, 16'h0000);
		check(a, v, e);
	endtask
	task idle(input logic [15:0] m);
		repeat (40) begin
			op(8'h08, 0, 16'h0000);
			if ((v & m) === 16'h0000) return;
		end
		err_count++;
		final_report;
	endtask
	task crc_add(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ w[i]) ? 16'h1021 : 16'h0000);
	endtask
	initial begin
		repeat (10) @(negedge SYS_CLK);
		RSTN = 1;
		rc(8'h08, 16'h0000);
		rc(8'h0a, 16'h0000);
		rc(8'h00, 16'h0000);
		$display("reset test done");
		op(8'h0d, 1, 16'hffff);
		rc(8'h0d, 16'hffff);
		op(8'h0e, 1, 16'h1111);
		rc(8'h08, 16'h0010);
		op(8'h0e, 1, 16'h2222);
		rc(8'h08, 16'h0110);
		idle(16'h0010);
		rc(8'h08, 16'h0000);
		op(8'h0e, 1, 16'h2222);
		idle(16'h0010);
		$display("program test done");
		crc = 16'h0000;
		CFG_START = 1;
		@(negedge SYS_CLK);
		CFG_START = 0;
		op(8'h0b, 1, 16'h003f);
		idle(16'h0001);
		rc(8'h0c, 16'h2222);
		idle(16'h0001);
		rc(8'h0c, 16'h5a01);
		idle(16'h0001);
		crc_add(16'h1111);
		crc_add(16'h2222);
		crc_add(16'h5a01);
		crc_add(16'h5a02);
		rc(8'h09, crc);
		CFG_STORED_CRC = crc;
		CFG_END = 1;
		@(negedge SYS_CLK);
		CFG_END = 0;
		rc(8'h08, 16'h0000);
		CFG_STORED_CRC = ~crc;
		CFG_END = 1;
		@(negedge SYS_CLK);
		CFG_END = 0;
		rc(8'h08, 16'h0020);
		rc(8'h0a, ~crc);
		$display("readback test done");
		RSTN = 0;
		repeat (2) @(negedge SYS_CLK);
		RSTN = 1;
		rc(8'h08, 16'h0000);
		rc(8'h09, 16'h0000);
		rc(8'h0a, 16'h0000);
		rc(8'h0b, 16'h0000);
		$display("mid-run reset test done");
		final_report;
	end
endmodule
